// File: io_fault_pkg.sv
// Shared constants and types for the I/O fault latch and reset control
package io_fault_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ     = 200000;
	localparam int TON_MS      = 60;
	localparam int TOFF_MS     = 30;
	localparam int DISC_MS     = 3;
	localparam int TON_CYCLES  = TON_MS * CLK_KHZ;
	localparam int TOFF_CYCLES = TOFF_MS * CLK_KHZ;
	localparam int DISC_CYCLES = DISC_MS * CLK_KHZ;
	localparam int CNT_W       = 25;

	// ----------------------------------------------------------------
	// Structure
	// ----------------------------------------------------------------
	localparam int NUM_CIRC  = 2;
	localparam int FILT_W    = 6;
	localparam int FILT_1A   = 0;
	localparam int FILT_1B   = 1;
	localparam int FILT_2A   = 2;
	localparam int FILT_2B   = 3;
	localparam int FILT_FB1  = 4;
	localparam int FILT_FB2  = 5;
	localparam int CAUSE_W   = 3;

	// ----------------------------------------------------------------
	// Reset values and feedback polarity
	// ----------------------------------------------------------------
	localparam logic ON_RST        = 1'b0;
	localparam logic SEEN_RST      = 1'b0;
	localparam logic FAULT_SIG_RST = 1'b1;
	localparam logic FB_INVERT     = 1'b1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum {
		ST_RUN,
		ST_FAULT
	} fault_state_e;

	typedef struct packed {
		logic a;
		logic b;
	} pair_s;

	typedef struct packed {
		logic ext;
		logic disc;
		logic fb;
	} cause_s;

endpackage : io_fault_pkg

// File: io_level_filter.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module io_level_filter #(
	parameter int W = 6
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level,
	output logic              o_valid
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;
	logic         valid_reg;
	logic [1:0]   fill_reg;

	// ----------------------------------------------------------------
	// Synchroniser chain, level taken when stages two and three agree
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					level_reg[g] <= 1'b0;
				end else if (s2_reg[g] == s3_reg[g]) begin
					level_reg[g] <= s3_reg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			fill_reg  <= 2'h0;
			valid_reg <= 1'b0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (fill_reg != 2'h3) begin
				fill_reg <= fill_reg + 2'h1;
			end
			valid_reg <= valid_reg | (fill_reg == 2'h3);
		end
	end

	assign o_level = level_reg;
	assign o_valid = valid_reg;

endmodule : io_level_filter

`default_nettype wire

// File: io_fault_reset_control.sv
// I/O fault latch, fault reset and power output switch-on control
`timescale 1ns/1ps
`default_nettype none

module io_fault_reset_control #(
	parameter int TON_CYCLES  = io_fault_pkg::TON_CYCLES,
	parameter int TOFF_CYCLES = io_fault_pkg::TOFF_CYCLES,
	parameter int DISC_CYCLES = io_fault_pkg::DISC_CYCLES,
	parameter int CNT_W       = io_fault_pkg::CNT_W
) (
	input  wire logic       I_MCLK,
	input  wire logic       I_RST,
	input  wire logic       I_FAST_OFF_IN_1A,
	input  wire logic       I_FAST_OFF_IN_1B,
	input  wire logic       I_FAST_OFF_IN_2A,
	input  wire logic       I_FAST_OFF_IN_2B,
	input  wire logic       I_FEEDBACK_IN_1,
	input  wire logic       I_FEEDBACK_IN_2,
	input  wire logic [1:0] I_FAULT_DETECT,
	input  wire logic       I_REBOOT_REQ,
	input  wire logic       I_DUAL_MODE,
	output logic            O_POWER_OUT_1_HIGH,
	output logic            O_POWER_OUT_1_LOW,
	output logic            O_POWER_OUT_2_HIGH,
	output logic            O_POWER_OUT_2_LOW,
	output logic            O_FAULT_SIGNAL_OUT,
	output logic [2:0]      O_FAULT_CAUSE
);

	localparam int NC = io_fault_pkg::NUM_CIRC;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [io_fault_pkg::FILT_W-1:0] raw_in;
	logic [io_fault_pkg::FILT_W-1:0] filt;
	logic                            filt_valid;

	io_fault_pkg::pair_s             pair       [NC];
	logic [NC-1:0]                   fb_level;
	logic [NC-1:0]                   circ_en;
	logic [NC-1:0]                   both_high;
	logic [NC-1:0]                   both_low;
	logic [NC-1:0]                   fall_evt;
	logic [NC-1:0]                   rise_evt;
	logic [NC-1:0]                   disc_err;
	logic [NC-1:0]                   fb_err;
	logic [NC-1:0]                   circ_fault;

	logic [NC-1:0]                   seen_high_reg;
	logic [NC-1:0]                   seen_high_next;
	logic [NC-1:0]                   seen_low_reg;
	logic [NC-1:0]                   seen_low_next;
	logic [NC-1:0]                   on_reg;
	logic [NC-1:0]                   on_next;
	logic [CNT_W-1:0]                disc_cnt_reg  [NC];
	logic [CNT_W-1:0]                disc_cnt_next [NC];
	logic [CNT_W-1:0]                fb_cnt_reg    [NC];
	logic [CNT_W-1:0]                fb_cnt_next   [NC];
	logic [CNT_W-1:0]                fb_limit      [NC];

	io_fault_pkg::fault_state_e      state_reg;
	io_fault_pkg::fault_state_e      state_next;
	io_fault_pkg::cause_s            cause_reg;
	io_fault_pkg::cause_s            cause_next;
	io_fault_pkg::cause_s            cause_now;
	logic                            fault_sig_reg;
	logic                            fault_set;
	logic                            fault_clr;
	logic                            in_fault;

	// ----------------------------------------------------------------
	// Input synchronisation and filtering
	// ----------------------------------------------------------------
	assign raw_in[io_fault_pkg::FILT_1A]  = I_FAST_OFF_IN_1A;
	assign raw_in[io_fault_pkg::FILT_1B]  = I_FAST_OFF_IN_1B;
	assign raw_in[io_fault_pkg::FILT_2A]  = I_FAST_OFF_IN_2A;
	assign raw_in[io_fault_pkg::FILT_2B]  = I_FAST_OFF_IN_2B;
	assign raw_in[io_fault_pkg::FILT_FB1] = I_FEEDBACK_IN_1;
	assign raw_in[io_fault_pkg::FILT_FB2] = I_FEEDBACK_IN_2;

	io_level_filter #(
		.W (io_fault_pkg::FILT_W)
	) u_filter (
		.i_clk   (I_MCLK),
		.i_rst   (I_RST),
		.i_async (raw_in),
		.o_level (filt),
		.o_valid (filt_valid)
	);

	// Pair one drives circuit 1, pair two drives circuit 2
	assign pair[0].a   = filt[io_fault_pkg::FILT_1A];
	assign pair[0].b   = filt[io_fault_pkg::FILT_1B];
	assign pair[1].a   = filt[io_fault_pkg::FILT_2A];
	assign pair[1].b   = filt[io_fault_pkg::FILT_2B];
	assign fb_level[0] = filt[io_fault_pkg::FILT_FB1];
	assign fb_level[1] = filt[io_fault_pkg::FILT_FB2];

	// Circuit 2 only switches on when dual-channel use is selected
	assign circ_en[0] = 1'b1;
	assign circ_en[1] = I_DUAL_MODE;

	assign in_fault = (state_reg == io_fault_pkg::ST_FAULT);

	// ----------------------------------------------------------------
	// Per-circuit edge detection, discrepancy and feedback checks
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < NC; c++) begin : g_circ

			assign both_high[c] = pair[c].a & pair[c].b;
			assign both_low[c]  = ~pair[c].a & ~pair[c].b;

			// Falling pair edge: both were high, now both low
			assign fall_evt[c] = filt_valid & seen_high_reg[c] & both_low[c];
			// Rising pair edge needs both low beforehand
			assign rise_evt[c] = filt_valid & seen_low_reg[c] & both_high[c];

			assign seen_high_next[c] = I_REBOOT_REQ ? io_fault_pkg::SEEN_RST :
				!filt_valid ? seen_high_reg[c] :
				both_high[c] ? 1'b1 :
				both_low[c] ? 1'b0 : seen_high_reg[c];
			assign seen_low_next[c] = I_REBOOT_REQ ? io_fault_pkg::SEEN_RST :
				!filt_valid ? seen_low_reg[c] :
				both_low[c] ? 1'b1 :
				both_high[c] ? 1'b0 : seen_low_reg[c];

			// Inputs of one pair disagreeing too long is a pair fault
			assign disc_cnt_next[c] = (in_fault | ~filt_valid | ~(pair[c].a ^ pair[c].b)) ?
				'0 :
				(disc_cnt_reg[c] == CNT_W'(DISC_CYCLES)) ? disc_cnt_reg[c] :
				disc_cnt_reg[c] + CNT_W'(1);
			assign disc_err[c] = (disc_cnt_reg[c] == CNT_W'(DISC_CYCLES));

			// Feedback must reach its expected level within the time window
			assign fb_limit[c] = on_reg[c] ? CNT_W'(TON_CYCLES) : CNT_W'(TOFF_CYCLES);
			assign fb_cnt_next[c] = (in_fault | ~filt_valid | (on_next[c] != on_reg[c])) ?
				'0 :
				(fb_cnt_reg[c] == fb_limit[c]) ? fb_cnt_reg[c] :
				fb_cnt_reg[c] + CNT_W'(1);
			assign fb_err[c] = (fb_cnt_reg[c] == fb_limit[c]) &
				(fb_level[c] != (on_reg[c] ^ io_fault_pkg::FB_INVERT));

			assign circ_fault[c] = disc_err[c] | fb_err[c] | I_FAULT_DETECT[c];

			// Output: off on any fault or reboot, off on falling pair, on on rising pair
			assign on_next[c] = (I_REBOOT_REQ | fault_set | in_fault) ? 1'b0 :
				fall_evt[c] ? 1'b0 :
				(rise_evt[c] & circ_en[c]) ? 1'b1 :
				on_reg[c];

			always_ff @(posedge I_MCLK) begin
				if (I_RST) begin
					seen_high_reg[c] <= io_fault_pkg::SEEN_RST;
					seen_low_reg[c]  <= io_fault_pkg::SEEN_RST;
					on_reg[c]        <= io_fault_pkg::ON_RST;
					disc_cnt_reg[c]  <= '0;
					fb_cnt_reg[c]    <= '0;
				end else begin
					seen_high_reg[c] <= seen_high_next[c];
					seen_low_reg[c]  <= seen_low_next[c];
					on_reg[c]        <= on_next[c];
					disc_cnt_reg[c]  <= disc_cnt_next[c];
					fb_cnt_reg[c]    <= fb_cnt_next[c];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Fault latch
	// ----------------------------------------------------------------
	assign cause_now.ext  = |I_FAULT_DETECT;
	assign cause_now.disc = |disc_err;
	assign cause_now.fb   = |fb_err;

	assign fault_set = |circ_fault;

	// Either falling pair clears; single and dual mode both accept one full pair
	assign fault_clr = in_fault & (I_REBOOT_REQ | (|fall_evt));

	always_comb begin
		state_next = state_reg;
		cause_next = cause_reg;
		case (state_reg)
			io_fault_pkg::ST_RUN: begin
				if (fault_set) begin
					state_next = io_fault_pkg::ST_FAULT;
					cause_next = cause_now;
				end
			end
			io_fault_pkg::ST_FAULT: begin
				if (fault_set) begin
					cause_next = cause_reg | cause_now;
				end else if (fault_clr) begin
					state_next = io_fault_pkg::ST_RUN;
					cause_next = '0;
				end
			end
			default: begin
				state_next = io_fault_pkg::ST_FAULT;
			end
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			state_reg     <= io_fault_pkg::ST_RUN;
			cause_reg     <= '0;
			fault_sig_reg <= io_fault_pkg::FAULT_SIG_RST;
		end else begin
			state_reg     <= state_next;
			cause_reg     <= cause_next;
			fault_sig_reg <= (state_next == io_fault_pkg::ST_RUN);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign O_POWER_OUT_1_HIGH = on_reg[0];
	assign O_POWER_OUT_1_LOW  = on_reg[0];
	assign O_POWER_OUT_2_HIGH = on_reg[1];
	assign O_POWER_OUT_2_LOW  = on_reg[1];
	assign O_FAULT_SIGNAL_OUT = fault_sig_reg;
	assign O_FAULT_CAUSE      = cause_reg;

endmodule : io_fault_reset_control

`default_nettype wire

// File: io_fault_reset_control_chk.sv
// Assertion checker for the I/O fault latch and reset control
`timescale 1ns/1ps
`default_nettype none
module io_fault_reset_control_chk (
	input wire logic       I_MCLK,
	input wire logic       I_RST,
	input wire logic       I_FAST_OFF_IN_1A,
	input wire logic       I_FAST_OFF_IN_1B,
	input wire logic       I_FAST_OFF_IN_2A,
	input wire logic       I_FAST_OFF_IN_2B,
	input wire logic [1:0] I_FAULT_DETECT,
	input wire logic       I_REBOOT_REQ,
	input wire logic       I_DUAL_MODE,
	input wire logic       O_POWER_OUT_1_HIGH,
	input wire logic       O_POWER_OUT_1_LOW,
	input wire logic       O_POWER_OUT_2_HIGH,
	input wire logic       O_POWER_OUT_2_LOW,
	input wire logic       O_FAULT_SIGNAL_OUT,
	input wire logic [2:0] O_FAULT_CAUSE
);
	// ----------------------------------------------------------------
	// Pin level run counters: 0 high 1, 1 high 2, 2 low 1, 3 low 2
	// ----------------------------------------------------------------
	wire logic [3:0] lvl_ok = {~I_FAST_OFF_IN_2A & ~I_FAST_OFF_IN_2B,
		~I_FAST_OFF_IN_1A & ~I_FAST_OFF_IN_1B,
		I_FAST_OFF_IN_2A & I_FAST_OFF_IN_2B, I_FAST_OFF_IN_1A & I_FAST_OFF_IN_1B};
	logic [3:0][2:0] runs;
	always_ff @(posedge I_MCLK) begin
		for (int i = 0; i < 4; i++) begin
			if (I_RST || !lvl_ok[i])
				runs[i] <= 3'h0;
			else if (runs[i] != 3'h7)
				runs[i] <= runs[i] + 3'h1;
		end
	end
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_fault_sets: assert property (|I_FAULT_DETECT |=>
		!O_FAULT_SIGNAL_OUT && O_FAULT_CAUSE[2]) else $error("Fault not latched");
	a_off_in_fault: assert property (!O_FAULT_SIGNAL_OUT |->
		!O_POWER_OUT_1_HIGH && !O_POWER_OUT_2_HIGH) else $error("Output on in fault");
	a_reset_clears: assert property (disable iff (1'b0) I_RST |=>
		O_FAULT_SIGNAL_OUT && O_FAULT_CAUSE == 3'h0 && !O_POWER_OUT_1_HIGH
		&& !O_POWER_OUT_2_HIGH) else $error("Reset did not clear");
	a_reboot_off: assert property (I_REBOOT_REQ |=>
		!O_POWER_OUT_1_HIGH && !O_POWER_OUT_2_HIGH) else $error("Reboot left output on");
	a_fault_holds: assert property ($rose(O_FAULT_SIGNAL_OUT) |->
		$past(I_RST) || $past(I_REBOOT_REQ) || runs[2] >= 3'h3 || runs[3] >= 3'h3)
		else $error("Fault cleared without reset action");
	a_on_pair1: assert property ($rose(O_POWER_OUT_1_HIGH) |->
		O_FAULT_SIGNAL_OUT && runs[0] >= 3'h3) else $error("Output 1 on without rise");
	a_on_pair2: assert property ($rose(O_POWER_OUT_2_HIGH) |->
		$past(I_DUAL_MODE) && runs[1] >= 3'h3) else $error("Output 2 on without rise");
	a_out_equal: assert property (O_POWER_OUT_1_HIGH == O_POWER_OUT_1_LOW
		&& O_POWER_OUT_2_HIGH == O_POWER_OUT_2_LOW) else $error("Output sides differ");
	a_fall_offs: assert property (runs[2] == 3'h7 |-> !O_POWER_OUT_1_HIGH)
		else $error("Output 1 on with pair low");
	c_fault: cover property ($fell(O_FAULT_SIGNAL_OUT));
	c_clear: cover property ($rose(O_FAULT_SIGNAL_OUT) && !$past(I_RST));
	c_on1: cover property ($rose(O_POWER_OUT_1_HIGH));
	c_on2: cover property ($rose(O_POWER_OUT_2_HIGH));
endmodule : io_fault_reset_control_chk
bind io_fault_reset_control io_fault_reset_control_chk u_chk (.I_MCLK(I_MCLK), .I_RST(I_RST),
	.I_FAST_OFF_IN_1A(I_FAST_OFF_IN_1A), .I_FAST_OFF_IN_1B(I_FAST_OFF_IN_1B),
	.I_FAST_OFF_IN_2A(I_FAST_OFF_IN_2A), .I_FAST_OFF_IN_2B(I_FAST_OFF_IN_2B),
	.I_FAULT_DETECT(I_FAULT_DETECT), .I_REBOOT_REQ(I_REBOOT_REQ), .I_DUAL_MODE(I_DUAL_MODE),
	.O_POWER_OUT_1_HIGH(O_POWER_OUT_1_HIGH), .O_POWER_OUT_1_LOW(O_POWER_OUT_1_LOW),
	.O_POWER_OUT_2_HIGH(O_POWER_OUT_2_HIGH), .O_POWER_OUT_2_LOW(O_POWER_OUT_2_LOW),
	.O_FAULT_SIGNAL_OUT(O_FAULT_SIGNAL_OUT), .O_FAULT_CAUSE(O_FAULT_CAUSE));
`default_nettype wire

// File: fast_off_host.sv
// Model of the controller driving the shutdown pairs and brake feedback
`timescale 1ns/1ps
`default_nettype none
module fast_off_host (
	input  wire logic                i_clk,
	input  wire io_fault_pkg::pair_s i_req_1,
	input  wire io_fault_pkg::pair_s i_req_2,
	input  wire logic                i_fb_stuck,
	input  wire logic                i_pwr_1,
	input  wire logic                i_pwr_2,
	output var io_fault_pkg::pair_s  o_pins_1,
	output var io_fault_pkg::pair_s  o_pins_2,
	output logic                     o_fb_1,
	output logic                     o_fb_2
);
	function automatic io_fault_pkg::pair_s step(input io_fault_pkg::pair_s cur,
		input io_fault_pkg::pair_s req);
		if (req == 2'b11 && cur != 2'b11 && cur != 2'b00)
			return 2'b00;
		return req;
	endfunction : step
	io_fault_pkg::pair_s req_1_reg;
	io_fault_pkg::pair_s req_2_reg;
	initial begin
		o_pins_1 = '0;
		o_pins_2 = '0;
	end
	// Requests taken on the rising edge, away from the bench's falling-edge drive
	always @(posedge i_clk) begin
		req_1_reg <= i_req_1;
		req_2_reg <= i_req_2;
	end
	// Pairs follow requests, except a rise from a split pair gives both low; falls are the reset actions, rises switch on
	always @(negedge i_clk) begin
		o_pins_1 <= step(o_pins_1, req_1_reg);
		o_pins_2 <= step(o_pins_2, req_2_reg);
	end
	// Normally closed feedback, high while the load is off
	assign o_fb_1 = i_fb_stuck | ~i_pwr_1;
	assign o_fb_2 = ~i_pwr_2;
endmodule : fast_off_host
`default_nettype wire

// File: tb_io_fault_reset_control.sv
// Self-checking testbench for the I/O fault latch and reset control
`timescale 1ns/1ps
`default_nettype none
module tb_io_fault_reset_control;
	logic                mclk = 1'b0;
	logic                rst = 1'b1;
	logic [1:0]          detect = 2'h0;
	logic                reboot = 1'b0;
	logic                dual = 1'b0;
	logic                fb_stuck = 1'b0;
	io_fault_pkg::pair_s req_1 = '0;
	io_fault_pkg::pair_s req_2 = '0;
	io_fault_pkg::pair_s pins_1;
	io_fault_pkg::pair_s pins_2;
	logic                fb_1, fb_2, p1h, p1l, p2h, p2l, fsig;
	logic [2:0]          cause;
	int                  n_errors = 0;
	int                  n_checks = 0;
	int                  cycles = 0;
	always #2.5 mclk = ~mclk;
	io_fault_reset_control #(.TON_CYCLES(20), .TOFF_CYCLES(20), .DISC_CYCLES(10)) dut (
		.I_MCLK(mclk), .I_RST(rst), .I_FAST_OFF_IN_1A(pins_1.a), .I_FAST_OFF_IN_1B(pins_1.b),
		.I_FAST_OFF_IN_2A(pins_2.a), .I_FAST_OFF_IN_2B(pins_2.b), .I_FEEDBACK_IN_1(fb_1),
		.I_FEEDBACK_IN_2(fb_2), .I_FAULT_DETECT(detect), .I_REBOOT_REQ(reboot),
		.I_DUAL_MODE(dual), .O_POWER_OUT_1_HIGH(p1h), .O_POWER_OUT_1_LOW(p1l),
		.O_POWER_OUT_2_HIGH(p2h), .O_POWER_OUT_2_LOW(p2l), .O_FAULT_SIGNAL_OUT(fsig),
		.O_FAULT_CAUSE(cause));
	fast_off_host host (.i_clk(mclk), .i_req_1(req_1), .i_req_2(req_2), .i_fb_stuck(fb_stuck),
		.i_pwr_1(p1h), .i_pwr_2(p2h), .o_pins_1(pins_1), .o_pins_2(pins_2), .o_fb_1(fb_1),
		.o_fb_2(fb_2));
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_cause(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_cause
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic pulse_detect(input logic [1:0] v);
		detect = v;
		cyc(1);
		detect = 2'h0;
	endtask : pulse_detect
	task automatic t_switch_on();
		req_1 = 2'b11;
		cyc(10);
		chk_bit(p1h, 1'b1);
		chk_bit(p2h, 1'b0);
		chk_bit(fsig, 1'b1);
		$display("Done switch on");
	endtask : t_switch_on
	task automatic t_fault_clear();
		pulse_detect(2'h1);
		chk_bit(fsig, 1'b0);
		chk_bit(p1h, 1'b0);
		chk_cause(cause, 3'h4);
		cyc(20);
		chk_bit(fsig, 1'b0);
		req_1 = 2'b00;
		cyc(10);
		chk_bit(fsig, 1'b1);
		chk_cause(cause, 3'h0);
		req_1 = 2'b11;
		cyc(10);
		chk_bit(p1h, 1'b1);
		$display("Done fault clear");
	endtask : t_fault_clear
	task automatic t_dual();
		dual = 1'b1;
		req_2 = 2'b11;
		cyc(10);
		chk_bit(p2h, 1'b1);
		pulse_detect(2'h2);
		chk_bit(p1h, 1'b0);
		chk_bit(p2h, 1'b0);
		req_2 = 2'b00;
		cyc(10);
		chk_bit(fsig, 1'b1);
		req_2 = 2'b11;
		cyc(10);
		chk_bit(p2h, 1'b1);
		chk_bit(p1h, 1'b0);
		$display("Done dual");
	endtask : t_dual
	task automatic t_reboot();
		reboot = 1'b1;
		cyc(1);
		reboot = 1'b0;
		chk_bit(p2h, 1'b0);
		cyc(15);
		chk_bit(p2h, 1'b0);
		pulse_detect(2'h1);
		reboot = 1'b1;
		cyc(1);
		reboot = 1'b0;
		chk_bit(fsig, 1'b1);
		$display("Done reboot");
	endtask : t_reboot
	task automatic t_single();
		dual = 1'b0;
		req_1 = 2'b00;
		req_2 = 2'b00;
		cyc(10);
		req_1 = 2'b11;
		req_2 = 2'b11;
		cyc(10);
		chk_bit(p1h, 1'b1);
		chk_bit(p1l, 1'b1);
		chk_bit(p2h, 1'b0);
		chk_bit(p2l, 1'b0);
		$display("Done single");
	endtask : t_single
	task automatic t_feedback();
		req_1 = 2'b00;
		cyc(10);
		fb_stuck = 1'b1;
		req_1 = 2'b11;
		cyc(10);
		chk_bit(fsig, 1'b1);
		cyc(25);
		chk_bit(fsig, 1'b0);
		chk_cause(cause, 3'h1);
		fb_stuck = 1'b0;
		$display("Done feedback");
	endtask : t_feedback
	task automatic t_reset();
		rst = 1'b1;
		cyc(2);
		chk_bit(fsig, 1'b1);
		chk_cause(cause, 3'h0);
		chk_bit(p1h, 1'b0);
		rst = 1'b0;
		cyc(6);
		$display("Done reset");
	endtask : t_reset
	task automatic t_disc();
		req_1 = 2'b10;
		cyc(30);
		chk_bit(fsig, 1'b0);
		chk_cause(cause, 3'h2);
		$display("Done mismatch");
	endtask : t_disc
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		cyc(6);
		rst = 1'b0;
		cyc(6);
		t_switch_on();
		t_fault_clear();
		t_dual();
		t_reboot();
		t_single();
		t_feedback();
		t_reset();
		t_disc();
		give_verdict();
	end
endmodule : tb_io_fault_reset_control
`default_nettype wire
